// [bench/cst_ana_model.sv]
`default_nettype none

module cst_ana_model
    import cst_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // Converter core
    input  wire logic                 ana_sample,
    input  wire logic                 ana_convert,
    input  wire logic [CST_RES_W-1:0] level,
    output logic      [CST_RES_W-1:0] ana_result
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Capacitor array
    // ----------------------------------------
    logic [CST_RES_W-1:0] held_q;
    logic                 valid_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held_q  <= '0;
            valid_q <= 1'b0;
        end else if (ana_sample) begin
            held_q  <= level;
            valid_q <= 1'b0;
        end else if (ana_convert) begin
            valid_q <= 1'b1;
        end
    end

    // Code is garbage until conversion has run
    assign ana_result = valid_q ? held_q : ~held_q;
endmodule

`default_nettype wire

// [bench/cst_seq_properties.sv]
`default_nettype none

module cst_seq_properties
    import cst_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  arst_n,
    // Register bus
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic [CST_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic [1:0]            s_axi_bresp,
    // Converter
    input wire logic                  ana_sample,
    input wire logic                  ana_convert,
    input wire logic                  conversion_busy_flag,
    input wire logic                  irq
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Span of each busy level since last edge
    // ----------------------------------------
    logic        b_q;
    logic        seen_q;
    logic        started_q;
    logic [15:0] cnt_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b_q       <= 1'h0;
            seen_q    <= 1'h0;
            started_q <= 1'h0;
            cnt_q     <= 16'h0001;
        end else begin
            b_q <= conversion_busy_flag;
            if (s_axi_awvalid && s_axi_awready
                && s_axi_awaddr == CST_OFS_RES_LO) begin
                started_q <= 1'h1;
            end
            if (conversion_busy_flag != b_q) begin
                seen_q <= 1'h1;
                cnt_q  <= 16'h0001;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_idle_until_start:
        assert property (!started_q |-> !conversion_busy_flag)
        else $error("busy before any start");
    a_run_whole_cycles:
        assert property (seen_q && b_q && !conversion_busy_flag |->
            cnt_q % 16'h0006 == 16'h0000 && cnt_q >= 16'h0030)
        else $error("run not whole machine cycles");
    a_gap_whole_cycles:
        assert property (seen_q && !b_q && conversion_busy_flag |->
            cnt_q % 16'h0006 == 16'h0000)
        else $error("idle gap off the cycle grid");
    a_write_cycle_low:
        assert property ($fell(conversion_busy_flag) |->
            !conversion_busy_flag [*6])
        else $error("write cycle shorter than six clocks");
    a_sample_first:
        assert property ($rose(conversion_busy_flag) |-> ##[0:1] ana_sample)
        else $error("run does not open with sampling");
    a_phase_excl:
        assert property (!(ana_sample && ana_convert))
        else $error("sample and convert overlap");
    a_convert_follows:
        assert property ($rose(ana_convert) |-> $past(ana_sample))
        else $error("convert not right after sample");
    a_phase_in_run:
        assert property (ana_sample || ana_convert |-> conversion_busy_flag)
        else $error("analog phase outside busy");
    a_irq_sticky:
        assert property (irq && s_axi_awready && s_axi_wready
            && !s_axi_awvalid && !s_axi_wvalid |=> irq)
        else $error("irq dropped without a write");

    c_restart: cover property ($fell(conversion_busy_flag) ##6
        conversion_busy_flag);
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == CST_RESP_SLVERR);
endmodule

bind cst_seq cst_seq_properties u_props (
    .clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
    .ana_sample, .ana_convert, .conversion_busy_flag, .irq
);

`default_nettype wire

// [bench/cst_seq_test.sv]
`default_nettype none

module cst_seq_test
    import cst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [1:0] OK = CST_RESP_OKAY;
    localparam logic [1:0] ER = CST_RESP_SLVERR;

    logic        clk, arst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic        busy, irq, smp, cnv;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd;
    logic [1:0]  bresp, rresp;
    logic [9:0]  lvl, res;
    int          mismatches, checks;
    int          cyc = 0;
    int          tots [4] = '{12, 14, 18, 26};

    cst_seq u_dut (
        .clk(clk), .arst_n(arst_n),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .ana_sample(smp),
        .ana_convert(cnv), .ana_result(res),
        .conversion_busy_flag(busy), .irq(irq)
    );

    cst_ana_model u_ana (
        .clk(clk), .arst_n(arst_n), .ana_sample(smp),
        .ana_convert(cnv), .level(lvl), .ana_result(res)
    );

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (wv && wr) begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end while (!(ad && dd));
        while (!bv) @(posedge clk);
        br <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        rr <= 1'b0;
        chk(rd, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic span(input logic v, output int n);
        n = 0;
        while (busy !== v) @(posedge clk);
        while (busy === v) begin
            n++;
            @(posedge clk);
        end
    endtask

    task automatic start(input logic [31:0] ctrl);
        wr_reg(CST_OFS_CTRL, ctrl, OK);
        wr_reg(CST_OFS_RES_LO, 32'h0, OK);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({31'h0, busy}, 32'h0);
        rd_chk(CST_OFS_CTRL, 32'h0, OK);
        rd_chk(CST_OFS_IRQ_STAT, 32'h0, OK);
        rd_chk(8'h18, 32'h0, ER);
        wr_reg(8'h18, 32'h1, ER);
        wr_reg(CST_OFS_STATUS, 32'h7, OK);
        rd_chk(CST_OFS_STATUS, 32'h0, OK);
        $display("reset test done");
    endtask

    task automatic t_single();
        int n, p;
        logic [9:0] lv;
        // Slowest two dividers keep the conversion clock legal
        for (int cd = 2; cd < 4; cd++) begin
            for (int sd = 0; sd < 4; sd++) begin
                p = (CST_DIV_BASE << cd) * tots[sd];
                lv = 10'h2A5 ^ 10'(p);
                lvl <= lv;
                start(32'((cd << CST_CTRL_CDIV) | (sd << CST_CTRL_SDIV)));
                span(1'b1, n);
                chk(n, (p + 5) / 6 * 6);
                chk({31'h0, irq}, 32'h0);
                rd_chk(CST_OFS_RES_HI, {24'h0, lv[9:2]}, OK);
                rd_chk(CST_OFS_RES_LO, {24'h0, lv[1:0], 6'h0}, OK);
                rd_chk(CST_OFS_STATUS, 32'((p % 6) / 2 * 2), OK);
                rd_chk(CST_OFS_IRQ_STAT, 32'h1, OK);
                wr_reg(CST_OFS_IRQ_STAT, 32'h1, OK);
            end
        end
        $display("single test done");
    endtask

    task automatic t_irq();
        int n;
        wr_reg(CST_OFS_IRQ_MASK, 32'h1, OK);
        start(32'h4);
        span(1'b1, n);
        chk({31'h0, irq}, 32'h1);
        repeat (30) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr_reg(CST_OFS_IRQ_MASK, 32'h0, OK);
        chk({31'h0, irq}, 32'h0);
        wr_reg(CST_OFS_IRQ_MASK, 32'h1, OK);
        wr_reg(CST_OFS_IRQ_STAT, 32'h1, OK);
        chk({31'h0, irq}, 32'h0);
        $display("irq test done");
    endtask

    task automatic t_cont();
        int n, t0;
        start(32'h5);
        span(1'b1, n);
        chk(n, 192);
        // Counted every clock, since polling may miss the gap
        span(1'b0, n);
        chk(n, 6);
        t0 = cyc;
        wr_reg(CST_OFS_CTRL, 32'h4, OK);
        span(1'b1, n);
        chk(cyc - t0, 192);
        n = 0;
        repeat (300) begin
            @(posedge clk);
            n += busy;
        end
        chk(n, 0);
        wr_reg(CST_OFS_IRQ_STAT, 32'h1, OK);
        $display("continuous test done");
    endtask

    task automatic t_abandon();
        int t0;
        start(32'h4);
        while (!busy) @(posedge clk);
        t0 = cyc;
        repeat (60) @(posedge clk);
        wr_reg(CST_OFS_RES_LO, 32'h0, OK);
        while (busy) @(posedge clk);
        chk(32'(cyc - t0 > 246 && cyc - t0 < 264), 32'h1);
        $display("restart test done");
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        {arst_n, awv, wv, br, arv, rr} = '0;
        {awa, ara, wd, lvl} = '0;
        mismatches = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_single();
        t_irq();
        t_cont();
        t_abandon();
        tally_and_finish();
    end
endmodule

`default_nettype wire

// [hdl/cst_mc_timer.sv]
`default_nettype none

module cst_mc_timer #(
    parameter int unsigned CLKS = 6
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Last input clock of each machine cycle
    output logic      last_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cnt;
        logic       last;
    } cst_mct_t;

    cst_mct_t q;
    cst_mct_t d;

    always_comb begin
        d = q;
        if (q.last) begin
            d.cnt = 4'h0;
        end else begin
            d.cnt = q.cnt + 4'h1;
        end
        d.last = (d.cnt == 4'(CLKS - 1));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign last_q = q.last;

endmodule

`default_nettype wire

// [hdl/cst_pkg.sv]
`default_nettype none

package cst_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned CST_ADDR_W       = 8;
    localparam logic [7:0]  CST_OFS_CTRL     = 8'h00;
    localparam logic [7:0]  CST_OFS_STATUS   = 8'h04;
    localparam logic [7:0]  CST_OFS_RES_LO   = 8'h08;
    localparam logic [7:0]  CST_OFS_RES_HI   = 8'h0C;
    localparam logic [7:0]  CST_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0]  CST_OFS_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CST_CTRL_CONT    = 0;
    localparam int unsigned CST_CTRL_CDIV    = 1;
    localparam int unsigned CST_CTRL_SDIV    = 3;
    localparam int unsigned CST_STAT_BUSY    = 0;
    localparam int unsigned CST_STAT_ALIGN   = 1;
    localparam int unsigned CST_RES_LO_POS   = 6;
    localparam int unsigned CST_RES_LO_BITS  = 2;
    localparam int unsigned CST_RES_W        = 10;
    localparam int unsigned CST_IRQ_DONE     = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CST_MC_CLKS      = 6;
    localparam int unsigned CST_DIV_BASE     = 4;
    localparam int unsigned CST_SAMPLE_BASE  = 2;
    localparam int unsigned CST_CONV_CLKS    = 10;
    localparam int unsigned CST_CNT_W        = 10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CST_IDLE  = 2'b00,
        CST_RUN   = 2'b01,
        CST_WRITE = 2'b10
    } cst_state_t;

    localparam logic [1:0] CST_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CST_RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// [hdl/cst_seq.sv]
`default_nettype none

// What this block does
// - Timing counts machine cycles of six input clocks each.
// - Any write to result_low_reg starts a conversion at the next machine cycle.
// - Phases end at cycle n; result registers written and readable in n+1.
// - Continuous mode restarts right after the write-result cycle unprompted.
// - Busy rises at first conversion cycle, falls at write-result cycle start.
// - In continuous mode busy is low for the single write-result cycle only.
// - Done flag set at conversion end; only software clears it.
// - Enabled interrupt request raised at start of n+1 for service by n+4/n+5.
// - Prescaler choice yields one of three machine-cycle alignments.
// - Divider 4/8/16/32; total 12/14/18/26 conversion clocks by sample code.
// - Writing result_low_reg during a conversion abandons it and restarts.
// - Clearing continuous bit lets current conversion finish, then stops.
// - Interrupt enable gates the request; the flag still sets.
module cst_seq
    import cst_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // AXI4-Lite write address
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [CST_ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // AXI4-Lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [CST_ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // Analog front end
    output logic                       ana_sample,
    output logic                       ana_convert,
    input  wire logic [CST_RES_W-1:0]  ana_result,
    // Status and interrupt
    output logic                       conversion_busy_flag,
    output logic                       irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        cst_state_t              st;
        logic                    pend;
        logic                    cont;
        logic [1:0]              cdiv;
        logic [1:0]              sdiv;
        logic [CST_CNT_W-1:0]    mc_left;
        logic [CST_CNT_W-1:0]    clk_cnt;
        logic [CST_CNT_W-1:0]    samp_clks;
        logic [CST_CNT_W-1:0]    run_clks;
        logic [CST_RES_W-1:0]    result;
        logic                    busy;
        logic                    sample;
        logic                    convert;
        logic                    done_flag;
        logic                    irq_en;
        logic                    irq;
        logic                    awready;
        logic                    wready;
        logic                    aw_seen;
        logic                    w_seen;
        logic [CST_ADDR_W-1:0]   awaddr;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
    } cst_regs_t;

    localparam cst_regs_t CST_RST = '{
        st:      CST_IDLE,
        awready: 1'h1,
        wready:  1'h1,
        arready: 1'h1,
        default: '0
    };

    cst_regs_t q;
    cst_regs_t n;

    logic mc_last;

    // ------------------------------------------------------------
    // Machine-cycle timer
    // ------------------------------------------------------------
    cst_mc_timer #(
        .CLKS   (CST_MC_CLKS)
    ) u_mc (
        .clk    (clk),
        .arst_n (arst_n),
        .last_q (mc_last)
    );

    // ------------------------------------------------------------
    // Conversion length helpers
    // ------------------------------------------------------------
    function automatic logic [CST_CNT_W-1:0] div_clks(
        input logic [1:0] c
    );
        return CST_CNT_W'(CST_DIV_BASE) << c;
    endfunction

    function automatic logic [CST_CNT_W-1:0] tot_clks(
        input logic [1:0] c,
        input logic [1:0] s
    );
        logic [CST_CNT_W-1:0] t;
        t = CST_CNT_W'(CST_CONV_CLKS) + (CST_CNT_W'(CST_SAMPLE_BASE) << s);
        return div_clks(c) * t;
    endfunction

    function automatic logic addr_ok(input logic [CST_ADDR_W-1:0] a);
        return (a == CST_OFS_CTRL) || (a == CST_OFS_STATUS) ||
               (a == CST_OFS_RES_LO) || (a == CST_OFS_RES_HI) ||
               (a == CST_OFS_IRQ_STAT) || (a == CST_OFS_IRQ_MASK);
    endfunction

    logic [CST_CNT_W-1:0] cfg_run;
    logic [CST_CNT_W-1:0] cfg_samp;
    logic [CST_CNT_W-1:0] cfg_mcs;
    logic [CST_CNT_W-1:0] cfg_rem;

    always_comb begin
        cfg_run  = tot_clks(q.cdiv, q.sdiv);
        cfg_samp = div_clks(q.cdiv) *
                   (CST_CNT_W'(CST_SAMPLE_BASE) << q.sdiv);
        cfg_mcs  = (cfg_run + CST_CNT_W'(CST_MC_CLKS - 1)) /
                   CST_CNT_W'(CST_MC_CLKS);
        cfg_rem  = cfg_run % CST_CNT_W'(CST_MC_CLKS);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic wr_do;
    logic start_wr;
    logic clr_done;
    logic set_done;
    logic go;

    always_comb begin
        n        = q;
        start_wr = 1'h0;
        clr_done = 1'h0;
        set_done = 1'h0;
        go       = 1'h0;

        // Write address and data, taken in either order
        if (s_axi_awvalid && q.awready) begin
            n.awaddr  = s_axi_awaddr;
            n.aw_seen = 1'h1;
            n.awready = 1'h0;
        end
        if (s_axi_wvalid && q.wready) begin
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
            n.w_seen = 1'h1;
            n.wready = 1'h0;
        end
        wr_do = q.aw_seen && q.w_seen && !q.bvalid;
        if (wr_do) begin
            n.bvalid  = 1'h1;
            n.aw_seen = 1'h0;
            n.w_seen  = 1'h0;
            n.bresp   = addr_ok(q.awaddr) ? CST_RESP_OKAY : CST_RESP_SLVERR;
            case (q.awaddr)
                CST_OFS_CTRL: begin
                    if (q.wstrb[0]) begin
                        n.cont = q.wdata[CST_CTRL_CONT];
                        n.cdiv = q.wdata[CST_CTRL_CDIV +: 2];
                        n.sdiv = q.wdata[CST_CTRL_SDIV +: 2];
                    end
                end
                CST_OFS_RES_LO: begin
                    start_wr = 1'h1;
                end
                CST_OFS_IRQ_STAT: begin
                    if (q.wstrb[0]) begin
                        clr_done = q.wdata[CST_IRQ_DONE];
                    end
                end
                CST_OFS_IRQ_MASK: begin
                    if (q.wstrb[0]) begin
                        n.irq_en = q.wdata[CST_IRQ_DONE];
                    end
                end
                default: begin
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid  = 1'h0;
            n.awready = 1'h1;
            n.wready  = 1'h1;
        end

        // Read channel
        if (s_axi_arvalid && q.arready) begin
            n.arready = 1'h0;
            n.rvalid  = 1'h1;
            n.rresp   = CST_RESP_OKAY;
            n.rdata   = 32'h0;
            case (s_axi_araddr)
                CST_OFS_CTRL: begin
                    n.rdata[CST_CTRL_CONT]      = q.cont;
                    n.rdata[CST_CTRL_CDIV +: 2] = q.cdiv;
                    n.rdata[CST_CTRL_SDIV +: 2] = q.sdiv;
                end
                CST_OFS_STATUS: begin
                    n.rdata[CST_STAT_BUSY]       = q.busy;
                    n.rdata[CST_STAT_ALIGN +: 2] = cfg_rem[2:1];
                end
                CST_OFS_RES_LO: begin
                    n.rdata[CST_RES_LO_POS +: CST_RES_LO_BITS] =
                        q.result[CST_RES_LO_BITS-1:0];
                end
                CST_OFS_RES_HI: begin
                    n.rdata[CST_RES_W-CST_RES_LO_BITS-1:0] =
                        q.result[CST_RES_W-1:CST_RES_LO_BITS];
                end
                CST_OFS_IRQ_STAT: begin
                    n.rdata[CST_IRQ_DONE] = q.done_flag;
                end
                CST_OFS_IRQ_MASK: begin
                    n.rdata[CST_IRQ_DONE] = q.irq_en;
                end
                default: begin
                    n.rresp = CST_RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            n.rvalid  = 1'h0;
            n.arready = 1'h1;
        end

        // Conversion sequencer, stepped on machine-cycle boundaries
        if (start_wr) begin
            n.pend = 1'h1;
        end
        if (q.st == CST_RUN && q.clk_cnt < q.run_clks) begin
            n.clk_cnt = q.clk_cnt + CST_CNT_W'(1);
        end
        if (mc_last) begin
            case (q.st)
                CST_IDLE: begin
                    go = n.pend;
                end
                CST_RUN: begin
                    if (n.pend) begin
                        go = 1'h1;
                    end else if (q.mc_left == CST_CNT_W'(1)) begin
                        n.st     = CST_WRITE;
                        n.busy   = 1'h0;
                        n.result = ana_result;
                        set_done = 1'h1;
                    end else begin
                        n.mc_left = q.mc_left - CST_CNT_W'(1);
                    end
                end
                CST_WRITE: begin
                    if (n.pend || q.cont) begin
                        go = 1'h1;
                    end else begin
                        n.st = CST_IDLE;
                    end
                end
                default: begin
                    n.st = CST_IDLE;
                end
            endcase
        end
        if (go) begin
            n.st        = CST_RUN;
            n.pend      = 1'h0;
            n.busy      = 1'h1;
            n.clk_cnt   = '0;
            n.run_clks  = cfg_run;
            n.samp_clks = cfg_samp;
            n.mc_left   = cfg_mcs;
        end

        // Analog phase strobes
        if (n.st == CST_RUN) begin
            n.sample  = n.clk_cnt < n.samp_clks;
            n.convert = !n.sample && (n.clk_cnt < n.run_clks);
        end else begin
            n.sample  = 1'h0;
            n.convert = 1'h0;
        end

        // Sticky done flag: a set wins over a clear in the same cycle
        if (clr_done) begin
            n.done_flag = 1'h0;
        end
        if (set_done) begin
            n.done_flag = 1'h1;
        end
        n.irq = n.done_flag && n.irq_en;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= CST_RST;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready        = q.awready;
    assign s_axi_wready         = q.wready;
    assign s_axi_bvalid         = q.bvalid;
    assign s_axi_bresp          = q.bresp;
    assign s_axi_arready        = q.arready;
    assign s_axi_rvalid         = q.rvalid;
    assign s_axi_rdata          = q.rdata;
    assign s_axi_rresp          = q.rresp;
    assign ana_sample           = q.sample;
    assign ana_convert          = q.convert;
    assign conversion_busy_flag = q.busy;
    assign irq                  = q.irq;

endmodule

`default_nettype wire
